// [rtl/pbl_boot_loader.sv]
`timescale 1ns/1ps
// Contract
// - boot control logic is active while the mode field holds mode 1.
// - on reset exit in boot mode, the read-only boot ROM maps at 0.
// - boot ROM stays mapped as long as the mode field stays boot.
// - during boot all program space is write-only; reads come from boot ROM.
// - after reset exit in boot mode, the core restarts fetching at 0.
// - loader ends by writing mode 2, unmapping ROM and restoring RAM reads.
// - switch to mode 2 is delayed one instruction plus a jump to zero.
// - software write of mode 1 maps the ROM in after the same delay.
// - outside boot the ROM gives no access path at all.
// - bit 23 of external word at c000 set selects external byte loading.
// - bit 23 clear selects loading each word from the host interface.
// - external bytes come low, mid, high from c000 up to c5ff.
// - host flag zero ends the load early and starts execution at 0.
// - in host mode the loader polls the host status register at ffe9.
module pbl_boot_loader
   import pbl_pkg::*;
#(
   parameter logic [3:0] EXT_WAIT = pbl_pkg::EXT_WAIT_CYCLES,
   parameter logic [pbl_pkg::ROM_WORDS*pbl_pkg::WORD_W-1:0] BOOT_ROM_IMAGE = '0
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pbl_pkg::WB_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [1:0] mode_pins_i,
   input wire logic [pbl_pkg::P_AW-1:0] core_adr_i,
   input wire logic core_rd_i,
   input wire logic core_wr_i,
   input wire logic [pbl_pkg::WORD_W-1:0] core_wdat_i,
   output logic [pbl_pkg::WORD_W-1:0] core_rdat_o,
   output logic core_restart_o,
   output logic boot_map_o,
   output logic [pbl_pkg::P_AW-1:0] ext_adr_o,
   output logic ext_rd_o,
   input wire logic [pbl_pkg::WORD_W-1:0] ext_dat_i,
   input wire logic [pbl_pkg::WORD_W-1:0] host_word_i,
   input wire logic host_rx_full_i,
   input wire logic host_flag_zero_i,
   output logic [pbl_pkg::P_AW-1:0] host_stat_adr_o,
   output logic host_poll_o,
   output logic host_rx_take_o
);
   import pbl_pkg::*;

   logic [1:0] strap_s1_reg, strap_s2_reg, strap_cnt_reg;
   logic strap_done_reg;
   logic [WORD_W-1:0] ext_s1_reg, ext_s2_reg;
   logic [1:0] mode_reg;
   logic [3:0] delay_cnt_reg;
   logic map_reg, restart_reg, load_start;
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic sw_mode_wr, ldr_mode_wr;
   pbl_state_t state_reg;
   logic [PROGRAM_RAM_AW-1:0] word_reg;
   logic [1:0] byte_reg;
   logic [3:0] wait_reg;
   logic [WORD_W-1:0] asm_reg;
   logic [P_AW-1:0] ext_adr_reg;
   logic ext_rd_reg, src_ext_reg, take_reg;
   logic [9:0] loaded_reg;
   logic [WORD_W-1:0] program_ram [PROGRAM_RAM_WORDS];
   logic [WORD_W-1:0] core_rdat_reg;

   // ************************************************************
   // input synchronisers
   // ************************************************************
   // pins are two-stage synchronised; only the second stage is read
   always_ff @(posedge clk_i)
   begin
      strap_s1_reg <= mode_pins_i;
      strap_s2_reg <= strap_s1_reg;
      ext_s1_reg <= ext_dat_i;
      ext_s2_reg <= ext_s1_reg;
   end

   // strap capture waits until the synchroniser holds post-reset pin levels
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         strap_cnt_reg <= 2'h0;
         strap_done_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         if (strap_cnt_reg == STRAP_CYCLES)
            strap_done_reg <= 1'b1;
         else
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
   end

   // ************************************************************
   // wishbone slave
   // ************************************************************
   assign sw_mode_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0]
                       && (wb_adr_i == REG_MODE);
   assign ldr_mode_wr = (state_reg == ST_FINISH);

   // one wait state; ack falls in the cycle after it was given
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
   end

   // unmapped addresses still ack, reading zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdat_reg <= 32'h0;
      else if (wb_cyc_i && wb_stb_i && !ack_reg)
      begin
         case (wb_adr_i)
            REG_MODE: rdat_reg <= {30'h0, mode_reg};
            REG_STATUS: rdat_reg <= {29'h0, state_reg != ST_IDLE, src_ext_reg, map_reg};
            REG_COUNT: rdat_reg <= {22'h0, loaded_reg};
            default: rdat_reg <= 32'h0;
         endcase
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ************************************************************
   // operating mode and boot ROM mapping
   // ************************************************************
   // loader write wins over a software write in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_reg <= MODE_RESET;
      else if (strap_done_reg == 1'b0 && strap_cnt_reg == STRAP_CYCLES)
         mode_reg <= strap_s2_reg;
      else if (ldr_mode_wr)
         mode_reg <= MODE_NORMAL;
      else if (sw_mode_wr)
         mode_reg <= wb_dat_i[1:0];
   end

   // a mode write arms the delay that lets one instruction and a jump run first
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         delay_cnt_reg <= 4'h0;
      else if (ldr_mode_wr || sw_mode_wr)
         delay_cnt_reg <= SWITCH_CYCLES;
      else if (delay_cnt_reg != 4'h0)
         delay_cnt_reg <= delay_cnt_reg - 4'h1;
   end

   // reset exit maps at once; later changes follow the mode after the delay
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         map_reg <= 1'b0;
         restart_reg <= 1'b0;
      end
      else if (strap_done_reg == 1'b0 && strap_cnt_reg == STRAP_CYCLES)
      begin
         map_reg <= (strap_s2_reg == MODE_BOOT);
         restart_reg <= 1'b1;
      end
      else if (delay_cnt_reg == 4'h1)
      begin
         map_reg <= (mode_reg == MODE_BOOT);
         restart_reg <= 1'b1;
      end
      else
         restart_reg <= 1'b0;
   end

   assign load_start = restart_reg && map_reg;
   assign core_restart_o = restart_reg;
   assign boot_map_o = map_reg;

   // ************************************************************
   // loader sequencer
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_IDLE;
         word_reg <= '0;
         byte_reg <= 2'h0;
         wait_reg <= 4'h0;
         asm_reg <= '0;
         ext_adr_reg <= EXT_BASE;
         ext_rd_reg <= 1'b0;
         src_ext_reg <= 1'b0;
         take_reg <= 1'b0;
      end
      else if (load_start)
      begin
         state_reg <= ST_PROBE;
         word_reg <= '0;
         byte_reg <= 2'h0;
         wait_reg <= EXT_WAIT;
         ext_adr_reg <= EXT_BASE;
         ext_rd_reg <= 1'b1;
         take_reg <= 1'b0;
      end
      else
      begin
         take_reg <= 1'b0;
         case (state_reg)
            ST_IDLE:
               ext_rd_reg <= 1'b0;
            ST_PROBE:
               if (wait_reg == 4'h1)
               begin
                  src_ext_reg <= ext_s2_reg[EXT_SEL_BIT];
                  wait_reg <= EXT_WAIT;
                  if (ext_s2_reg[EXT_SEL_BIT])
                     state_reg <= ST_EXT_RD;
                  else
                  begin
                     ext_rd_reg <= 1'b0;
                     state_reg <= ST_HOST_POLL;
                  end
               end
               else
                  wait_reg <= wait_reg - 4'h1;
            ST_EXT_RD:
               if (wait_reg == 4'h1)
               begin
                  // low byte first, shifted down so high lands on top
                  asm_reg <= {ext_s2_reg[7:0], asm_reg[WORD_W-1:8]};
                  ext_adr_reg <= ext_adr_reg + 16'h1;
                  wait_reg <= EXT_WAIT;
                  if (byte_reg == 2'h2)
                  begin
                     byte_reg <= 2'h0;
                     ext_rd_reg <= 1'b0;
                     state_reg <= ST_STORE;
                  end
                  else
                     byte_reg <= byte_reg + 2'h1;
               end
               else
                  wait_reg <= wait_reg - 4'h1;
            ST_HOST_POLL:
               // no handshake back to the host beyond the take pulse
               if (host_flag_zero_i)
                  state_reg <= ST_FINISH;
               else if (host_rx_full_i)
               begin
                  asm_reg <= host_word_i;
                  take_reg <= 1'b1;
                  state_reg <= ST_STORE;
               end
            ST_STORE:
               if (word_reg == LAST_WORD)
                  state_reg <= ST_FINISH;
               else
               begin
                  word_reg <= word_reg + 9'h1;
                  if (src_ext_reg)
                  begin
                     ext_rd_reg <= 1'b1;
                     state_reg <= ST_EXT_RD;
                  end
                  else
                     state_reg <= ST_HOST_POLL;
               end
            ST_FINISH:
               state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // words stored since the last boot start
   always_ff @(posedge clk_i)
   begin
      if (rst_i || load_start)
         loaded_reg <= 10'h0;
      else if (state_reg == ST_STORE)
         loaded_reg <= loaded_reg + 10'h1;
   end

   assign ext_adr_o = ext_adr_reg;
   assign ext_rd_o = ext_rd_reg;
   assign host_poll_o = (state_reg == ST_HOST_POLL);
   assign host_stat_adr_o = HOST_STAT_ADDR;
   assign host_rx_take_o = take_reg;

   // ************************************************************
   // program RAM and boot ROM read path
   // ************************************************************
   // the loader store takes the port; core writes land while mapped too
   always_ff @(posedge clk_i)
   begin
      if (state_reg == ST_STORE)
         program_ram[word_reg] <= asm_reg;
      else if (core_wr_i && core_adr_i[P_AW-1:PROGRAM_RAM_AW] == '0)
         program_ram[core_adr_i[PROGRAM_RAM_AW-1:0]] <= core_wdat_i;
   end

   // while mapped every read comes from the ROM; otherwise it is unreachable
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         core_rdat_reg <= '0;
      else if (core_rd_i)
      begin
         if (map_reg)
            core_rdat_reg <= BOOT_ROM_IMAGE[core_adr_i[ROM_AW-1:0]*WORD_W +: WORD_W];
         else if (core_adr_i[P_AW-1:PROGRAM_RAM_AW] == '0)
            core_rdat_reg <= program_ram[core_adr_i[PROGRAM_RAM_AW-1:0]];
         else
            core_rdat_reg <= '0;
      end
   end

   assign core_rdat_o = core_rdat_reg;

   // ************************************************************
   // assertions
   // ************************************************************
   ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   unmap_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_reg == ST_FINISH && !sw_mode_wr) |=> ##1 map_reg == $past(map_reg, 2) ##1 !map_reg)
      else $error("mode 2 unmap not on the third cycle");
   remap_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (sw_mode_wr && !ldr_mode_wr && wb_dat_i[1:0] == MODE_BOOT) ##1 !(ldr_mode_wr || sw_mode_wr)
      ##1 !(ldr_mode_wr || sw_mode_wr) |=> map_reg && restart_reg)
      else $error("mode 1 write did not remap after delay");
   map_follows_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (map_reg && delay_cnt_reg == 4'h0 && strap_done_reg) |-> mode_reg == MODE_BOOT)
      else $error("rom mapped while mode is not boot");
   rom_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (core_rd_i && map_reg) |=>
      core_rdat_o == BOOT_ROM_IMAGE[$past(core_adr_i[ROM_AW-1:0])*WORD_W +: WORD_W])
      else $error("mapped read not served from boot rom");
   ext_select_a: assert property (@(posedge clk_i) disable iff (rst_i || load_start)
      (state_reg == ST_PROBE && wait_reg == 4'h1) |=>
      src_ext_reg == $past(ext_s2_reg[EXT_SEL_BIT]))
      else $error("source select does not follow bit 23");
   ext_byte_addr_a: assert property (@(posedge clk_i) disable iff (rst_i || load_start)
      (state_reg == ST_STORE && src_ext_reg) |-> ext_adr_reg == EXT_BASE + 16'h3 *
      {7'h0, word_reg} + 16'h3)
      else $error("external byte address out of step");
   host_exit_a: assert property (@(posedge clk_i) disable iff (rst_i || load_start)
      (state_reg == ST_HOST_POLL && host_flag_zero_i) |=> state_reg == ST_FINISH ##1
      mode_reg == MODE_NORMAL)
      else $error("host flag zero did not end the load");
   word_step_a: assert property (@(posedge clk_i) disable iff (rst_i || load_start)
      (state_reg == ST_STORE && word_reg != LAST_WORD) |=> word_reg == $past(word_reg) + 9'h1)
      else $error("store address did not step by one");
endmodule

// [rtl/pbl_pkg.sv]
package pbl_pkg;
   // ************************************************************
   // register map of the wishbone slave (byte addresses)
   // ************************************************************
   localparam int WB_AW = 8;
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam int STAT_MAP_BIT = 0;
   localparam int STAT_EXT_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;

   // ************************************************************
   // operating modes
   // ************************************************************
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] MODE_BOOT = 2'h1;
   localparam logic [1:0] MODE_NORMAL = 2'h2;

   // ************************************************************
   // memory geometry and addresses
   // ************************************************************
   localparam int WORD_W = 24;
   localparam int P_AW = 16;
   localparam int PROGRAM_RAM_AW = 9;
   localparam int PROGRAM_RAM_WORDS = 512;
   localparam int ROM_AW = 5;
   localparam int ROM_WORDS = 32;
   localparam logic [P_AW-1:0] BOOT_ROM_BASE = 16'h0000;
   localparam logic [P_AW-1:0] EXT_BASE = 16'hc000;
   localparam logic [P_AW-1:0] EXT_LAST = 16'hc5ff;
   localparam logic [P_AW-1:0] HOST_STAT_ADDR = 16'hffe9;
   localparam logic [PROGRAM_RAM_AW-1:0] LAST_WORD = 9'h1ff;
   localparam int EXT_SEL_BIT = 23;

   // ************************************************************
   // timing counts (core clock cycles)
   // ************************************************************
   localparam logic [3:0] SWITCH_CYCLES = 4'h2;
   localparam logic [3:0] EXT_WAIT_CYCLES = 4'h3;
   localparam logic [1:0] STRAP_CYCLES = 2'h2;

   // loader sequencer
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PROBE,
      ST_EXT_RD,
      ST_HOST_POLL,
      ST_STORE,
      ST_FINISH
   } pbl_state_t;
endpackage

// [dv/pbl_far_side_model.sv]
`timescale 1ns/1ps
// ****************************************************
// far side: byte-wide memory on the expansion port and a host writer
// ****************************************************
module pbl_far_side_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ext_sel_i,
   input wire logic [15:0] ext_adr_i,
   input wire logic ext_rd_i,
   output logic [23:0] ext_dat_o,
   input wire logic host_en_i,
   input wire logic [9:0] host_words_i,
   input wire logic host_rx_take_i,
   output logic [23:0] host_word_o,
   output logic host_rx_full_o,
   output logic host_flag_zero_o
);
   import pbl_pkg::*;
   logic [9:0] idx_reg;

   // one byte per address, source flag on bit 23; the memory settles within the address
   // cycle, since the loader's two synchroniser stages take two of its three wait cycles
   // a released bus shows the inverse so nothing stale can pass as data
   assign ext_dat_o = ext_rd_i ? {ext_sel_i, 15'h0, ext_adr_i[7:0] ^ ext_adr_i[15:8]} :
                      ~{ext_sel_i, 15'h0, ext_adr_i[7:0] ^ ext_adr_i[15:8]};

   // host hands words over in order, starting again whenever it is re-enabled
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !host_en_i)
         idx_reg <= 10'h0;
      else if (host_rx_take_i)
         idx_reg <= idx_reg + 10'h1;
   end

   // no handshake beyond holding full until the word is taken
   assign host_rx_full_o = host_en_i && (idx_reg < host_words_i);
   assign host_flag_zero_o = host_en_i && (idx_reg >= host_words_i);
   assign host_word_o = host_rx_full_o ? (24'h3c0000 | {14'h0, idx_reg}) :
                        ~(24'h3c0000 | {14'h0, idx_reg});
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
   import pbl_pkg::*;
   // ****************************************************
   // expectations
   // ****************************************************
   function automatic logic [ROM_WORDS*WORD_W-1:0] rom_image();
      logic [ROM_WORDS*WORD_W-1:0] img;
      img = '0;
      for (int i = 0; i < ROM_WORDS; i++)
         img[i*WORD_W +: WORD_W] = 24'hb00000 | 24'(i);
      return img;
   endfunction
   function automatic logic [7:0] eb(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction
   function automatic logic [23:0] ext_word(input int n);
      logic [15:0] a;
      a = EXT_BASE + 16'(3 * n);
      return {eb(a + 16'h2), eb(a + 16'h1), eb(a)};
   endfunction
   localparam logic [ROM_WORDS*WORD_W-1:0] ROM_IMG = rom_image();

   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, core_rd_i, core_restart_o;
   logic boot_map_o, ext_rd_o, host_rx_full_i, host_flag_zero_i, host_poll_o, host_rx_take_o;
   logic ext_sel, host_en, core_wr_i;
   logic [23:0] core_wdat_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [1:0] mode_pins_i;
   logic [15:0] core_adr_i, ext_adr_o, host_stat_adr_o;
   logic [23:0] core_rdat_o, ext_dat_i, host_word_i, rd24;
   logic [9:0] host_words;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n;

   // 200 MHz core clock
   initial clk_i = 1'b0;
   always #2.5 clk_i = ~clk_i;

   pbl_boot_loader #(.BOOT_ROM_IMAGE(ROM_IMG)) u_pbl_boot_loader (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_pins_i(mode_pins_i),
      .core_adr_i(core_adr_i), .core_rd_i(core_rd_i), .core_wr_i(core_wr_i),
      .core_wdat_i(core_wdat_i), .core_rdat_o(core_rdat_o), .core_restart_o(core_restart_o),
      .boot_map_o(boot_map_o), .ext_adr_o(ext_adr_o), .ext_rd_o(ext_rd_o),
      .ext_dat_i(ext_dat_i), .host_word_i(host_word_i), .host_rx_full_i(host_rx_full_i),
      .host_flag_zero_i(host_flag_zero_i), .host_stat_adr_o(host_stat_adr_o),
      .host_poll_o(host_poll_o), .host_rx_take_o(host_rx_take_o));

   pbl_far_side_model u_pbl_far_side_model (
      .clk_i(clk_i), .rst_i(rst_i), .ext_sel_i(ext_sel), .ext_adr_i(ext_adr_o),
      .ext_rd_i(ext_rd_o), .ext_dat_o(ext_dat_i), .host_en_i(host_en),
      .host_words_i(host_words), .host_rx_take_i(host_rx_take_o), .host_word_o(host_word_i),
      .host_rx_full_o(host_rx_full_i), .host_flag_zero_o(host_flag_zero_i));

   // ****************************************************
   // helpers; every task starts and ends just after a rising edge
   // ****************************************************
   task automatic report_and_stop();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hf;
      // ack is sampled as it stood at the edge, read data taken at that same edge
      do
      begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
      if (k >= 20)
      begin
         check(0, 1, "bus ack timeout");
         report_and_stop();
      end
   endtask
   task automatic core_read(input logic [15:0] adr);
      core_adr_i <= adr;
      core_rd_i <= 1'b1;
      @(posedge clk_i);
      core_rd_i <= 1'b0;
      #1 rd24 = core_rdat_o;
      @(posedge clk_i);
   endtask
   task automatic core_write(input logic [15:0] adr, input logic [23:0] wd);
      core_adr_i <= adr;
      core_wdat_i <= wd;
      core_wr_i <= 1'b1;
      @(posedge clk_i);
      core_wr_i <= 1'b0;
   endtask
   task automatic wait_restart(input int bound);
      n = 0;
      while (core_restart_o !== 1'b1 && n < bound)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= bound)
      begin
         check(0, 1, "restart timeout");
         report_and_stop();
      end
   endtask

   // ****************************************************
   // main sequence
   // ****************************************************
   initial
   begin
      rst_i = 1'b1;
      mode_pins_i = MODE_BOOT;
      {wb_cyc_i, wb_stb_i, wb_we_i, core_rd_i} = 4'h0;
      core_wr_i = 1'b0;
      core_wdat_i = 24'h0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      core_adr_i = 16'h0;
      ext_sel = 1'b1;
      host_en = 1'b0;
      host_words = 10'h5;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      // strap in boot mode: rom mapped, core restarted, reads come from rom
      wait_restart(20);
      check(boot_map_o, 1, "map after reset");
      core_read(16'h0003);
      check(rd24, ROM_IMG[3*WORD_W +: WORD_W], "rom read");
      core_read(16'h0123);
      check(rd24, ROM_IMG[3*WORD_W +: WORD_W], "rom read any address");
      wb_rw(1'b0, REG_MODE, 32'h0);
      check(rd, 32'(MODE_BOOT), "mode during load");
      wb_rw(1'b0, REG_STATUS, 32'h0);
      check(rd[STAT_MAP_BIT], 1, "status map");
      // external load of all 512 words ends on its own
      wait_restart(12000);
      check(boot_map_o, 0, "unmapped after load");
      wb_rw(1'b0, REG_MODE, 32'h0);
      check(rd, 32'(MODE_NORMAL), "mode after load");
      wb_rw(1'b0, REG_COUNT, 32'h0);
      check(rd, 32'h200, "word count");
      for (int w = 0; w < 512; w += 73)
      begin
         core_read(16'(w));
         check({8'h0, rd24}, {8'h0, ext_word(w)}, "external word");
      end
      core_read(16'h01ff);
      check({8'h0, rd24}, {8'h0, ext_word(511)}, "last external word");
      core_read(16'h0200);
      check({8'h0, rd24}, 32'h0, "no rom outside boot");
      wb_rw(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0, "unmapped register");
      // software reboot through the host path, cut short by the flag
      ext_sel <= 1'b0;
      host_en <= 1'b1;
      wb_rw(1'b1, REG_MODE, {30'h0, MODE_BOOT});
      wait_restart(20);
      check(boot_map_o, 1, "map after reboot");
      // the loader is still probing here, so this write does not meet a store
      core_write(16'h0010, 24'h123456);
      n = 0;
      while (host_poll_o !== 1'b1 && n < 100)
      begin
         @(posedge clk_i);
         n++;
      end
      check(host_poll_o, 1, "host polling");
      check({16'h0, host_stat_adr_o}, {16'h0, HOST_STAT_ADDR}, "poll address");
      wait_restart(400);
      check(boot_map_o, 0, "early exit");
      wb_rw(1'b0, REG_COUNT, 32'h0);
      check(rd, 32'h5, "host word count");
      for (int w = 0; w < 6; w++)
      begin
         core_read(16'(w));
         check({8'h0, rd24}, (w < 5) ? (32'h3c0000 | w) : {8'h0, ext_word(w)}, "host word");
      end
      core_read(16'h0010);
      check({8'h0, rd24}, 32'h123456, "core write while mapped");
      host_en <= 1'b0;
      report_and_stop();
   end
endmodule
